// File: verilog/bof_defines.svh
// Offsets, field positions, reset values and cycle counts of the bit-op block
`ifndef BOF_DEFINES_SVH
`define BOF_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte addresses and address region codes
// ----------------------------------------------------------------------------
`define BOF_ADDR_CMD        8'h00
`define BOF_ADDR_STATUS     8'h04
`define BOF_ADDR_FLAG       8'h08
`define BOF_ADDR_PC         8'h0c
`define BOF_IO_REGION       3'h2
`define BOF_GPR_REGION      1'h1

// ----------------------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------------------
`define BOF_CMD_OP_LSB      0
`define BOF_CMD_IDX_LSB     8
`define BOF_CMD_BIT_LSB     16
`define BOF_CMD_OFF_LSB     24
`define BOF_OP_COUNT        5'h12

// ----------------------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------------------
`define BOF_ST_BUSY         0
`define BOF_ST_ILLEGAL      1
`define BOF_ST_TAKEN        2
`define BOF_ST_REFUSED      3
`define BOF_ST_CYC_LSB      8

// ----------------------------------------------------------------------------
// Status flag bit positions
// ----------------------------------------------------------------------------
`define BOF_FLAG_C          0
`define BOF_FLAG_Z          1
`define BOF_FLAG_N          2
`define BOF_FLAG_V          3
`define BOF_FLAG_S          4
`define BOF_FLAG_H          5
`define BOF_FLAG_T          6
`define BOF_FLAG_I          7

// ----------------------------------------------------------------------------
// Reset values, cycle counts and response codes
// ----------------------------------------------------------------------------
`define BOF_FLAG_RESET      8'h00
`define BOF_PC_RESET        16'h0000
`define BOF_CYC_SHORT       4'h1
`define BOF_CYC_LONG        4'h2
`define BOF_RESP_OKAY       2'h0
`define BOF_RESP_SLVERR     2'h2

`endif

// File: verilog/bof_pkg.sv
// Types shared by the bit-op datapath
package bof_pkg;

    typedef enum logic [4:0] {
        op_nop,
        op_branch_if_interrupts_on,
        op_branch_if_interrupts_off,
        op_set_io_bit,
        op_clear_io_bit,
        op_logical_shift_left,
        op_logical_shift_right,
        op_rotate_left_through_carry,
        op_rotate_right_through_carry,
        op_arithmetic_shift_right,
        op_bit_store_to_transfer_flag,
        op_bit_load_from_transfer_flag,
        op_set_signed_flag,
        op_clear_signed_flag,
        op_set_overflow_flag,
        op_clear_overflow_flag,
        op_set_half_carry_flag,
        op_clear_half_carry_flag
    } bof_op_type;

    typedef enum logic [1:0] {
        st_idle,
        st_exec,
        st_wait
    } bof_state_type;

endpackage : bof_pkg

// File: verilog/bof_regfile.sv
// General register file with one write port and two registered read ports
`timescale 1ns/1ps

module bof_regfile #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Write port
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // Read ports
    input  wire logic [AW-1:0]    a_addr,
    output logic      [WIDTH-1:0] a_data,
    input  wire logic [AW-1:0]    b_addr,
    output logic      [WIDTH-1:0] b_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge aclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read data registered; a read beside a write sees the old word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_data <= '0;
            b_data <= '0;
        end else begin
            a_data <= mem[a_addr];
            b_data <= mem[b_addr];
        end
    end

endmodule : bof_regfile

// File: verilog/bof_datapath.sv
// Bit, shift, flag and interrupt-branch datapath with an AXI4-Lite port
// ----------------------------------------------------------------------------
// Notes on behaviour
// - Branch on interrupts on: pc plus offset plus one
// - Branch on interrupts off: pc plus offset plus one
// - Set I/O bit, two cycles, flags kept
// - Clear I/O bit, two cycles, flags kept
// - Shift left, zero in, flags Z C N V
// - Shift right, zero into bit 7, flags
// - Rotate left via carry, flags Z C N V
// - Rotate right via carry, flags Z C N V
// - Arithmetic right shift keeps bit 7, flags
// - Register bit copied into transfer flag only
// - Transfer flag copied into register bit
// - Set and clear signed flag alone
// - Set and clear overflow flag alone
// - Set and clear half carry flag alone
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`include "bof_defines.svh"

module bof_datapath
    import bof_pkg::*;
#(
    parameter int ADDR_W   = 8,
    parameter int PC_W     = 16,
    parameter int GPR_N    = 32,
    parameter int IO_N     = 8
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Write address channel
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output logic                   awready,
    // Write data channel
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // Write response channel
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // Read address channel
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output logic                   arready,
    // Read data channel
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    bof_state_type     state;
    bof_op_type        op_q;
    logic [4:0]        idx_q;
    logic [2:0]        bit_q;
    logic [6:0]        off_q;
    logic [7:0]        flag;
    logic [PC_W-1:0]   pc;
    logic [7:0]        io_reg [IO_N];
    logic              illegal;
    logic              refused;
    logic              taken_q;
    logic [3:0]        cycles_q;
    logic              aw_have;
    logic              w_have;
    logic [ADDR_W-1:0] waddr_q;
    logic [31:0]       wdata_q;
    logic [ADDR_W-1:0] raddr_q;
    logic [1:0]        rd_stage;
    logic [7:0]        opnd;
    logic [7:0]        gpr_rd;

    // ------------------------------------------------------------------------
    // Write path decode
    // ------------------------------------------------------------------------
    logic fire;
    logic busy;
    logic sel_cmd;
    logic sel_flag;
    logic sel_pc;
    logic sel_io;
    logic sel_gpr;
    logic launch;
    logic legal_op;
    logic w_ok;

    assign fire     = aw_have && w_have && !bvalid;
    assign busy     = (state != st_idle);
    assign sel_cmd  = (waddr_q == `BOF_ADDR_CMD);
    assign sel_flag = (waddr_q == `BOF_ADDR_FLAG);
    assign sel_pc   = (waddr_q == `BOF_ADDR_PC);
    assign sel_io   = (waddr_q[7:5] == `BOF_IO_REGION);
    assign sel_gpr  = (waddr_q[7] == `BOF_GPR_REGION);
    assign legal_op = (wdata_q[`BOF_CMD_OP_LSB +: 5] < `BOF_OP_COUNT);
    assign launch   = fire && sel_cmd && !busy && legal_op;
    // Writes while an operation runs are refused rather than queued
    assign w_ok     = !busy && (sel_cmd || sel_flag || sel_pc || sel_io
                                || sel_gpr);

    // ------------------------------------------------------------------------
    // Execute stage
    // ------------------------------------------------------------------------
    logic [7:0]      res;
    logic [7:0]      next_flag;
    logic            carry;
    logic            gpr_we;
    logic            io_we;
    logic            io_val;
    logic            long_op;
    logic            shift_op;
    logic [PC_W-1:0] next_pc;

    always_comb begin
        res       = opnd;
        carry     = flag[`BOF_FLAG_C];
        next_flag = flag;
        gpr_we    = 1'b0;
        io_we     = 1'b0;
        io_val    = 1'b0;
        long_op   = 1'b0;
        shift_op  = 1'b0;
        unique case (op_q)
            op_nop: begin
            end
            op_branch_if_interrupts_on: begin
                long_op = flag[`BOF_FLAG_I];
            end
            op_branch_if_interrupts_off: begin
                long_op = !flag[`BOF_FLAG_I];
            end
            op_set_io_bit: begin
                io_we   = 1'b1;
                io_val  = 1'b1;
                long_op = 1'b1;
            end
            op_clear_io_bit: begin
                io_we   = 1'b1;
                io_val  = 1'b0;
                long_op = 1'b1;
            end
            op_logical_shift_left: begin
                res      = {opnd[6:0], 1'b0};
                carry    = opnd[7];
                shift_op = 1'b1;
            end
            op_logical_shift_right: begin
                res      = {1'b0, opnd[7:1]};
                carry    = opnd[0];
                shift_op = 1'b1;
            end
            op_rotate_left_through_carry: begin
                res      = {opnd[6:0], flag[`BOF_FLAG_C]};
                carry    = opnd[7];
                shift_op = 1'b1;
            end
            op_rotate_right_through_carry: begin
                res      = {flag[`BOF_FLAG_C], opnd[7:1]};
                carry    = opnd[0];
                shift_op = 1'b1;
            end
            op_arithmetic_shift_right: begin
                res      = {opnd[7], opnd[7:1]};
                carry    = opnd[0];
                shift_op = 1'b1;
            end
            op_bit_store_to_transfer_flag: begin
                next_flag[`BOF_FLAG_T] = opnd[bit_q];
            end
            op_bit_load_from_transfer_flag: begin
                res[bit_q] = flag[`BOF_FLAG_T];
                gpr_we     = 1'b1;
            end
            op_set_signed_flag: begin
                next_flag[`BOF_FLAG_S] = 1'b1;
            end
            op_clear_signed_flag: begin
                next_flag[`BOF_FLAG_S] = 1'b0;
            end
            op_set_overflow_flag: begin
                next_flag[`BOF_FLAG_V] = 1'b1;
            end
            op_clear_overflow_flag: begin
                next_flag[`BOF_FLAG_V] = 1'b0;
            end
            op_set_half_carry_flag: begin
                next_flag[`BOF_FLAG_H] = 1'b1;
            end
            op_clear_half_carry_flag: begin
                next_flag[`BOF_FLAG_H] = 1'b0;
            end
            default: begin
            end
        endcase
        // Shared flag update of all five shifts; S is left alone
        if (shift_op) begin
            gpr_we                 = 1'b1;
            next_flag[`BOF_FLAG_Z] = (res == 8'h00);
            next_flag[`BOF_FLAG_C] = carry;
            next_flag[`BOF_FLAG_N] = res[7];
            next_flag[`BOF_FLAG_V] = res[7] ^ carry;
        end
    end

    // Taken branches go to pc + k + 1, everything else to pc + 1
    logic is_branch;
    assign is_branch = (op_q == op_branch_if_interrupts_on)
                    || (op_q == op_branch_if_interrupts_off);
    assign next_pc   = (is_branch && long_op)
                     ? pc + {{(PC_W-7){off_q[6]}}, off_q}
                          + {{(PC_W-1){1'b0}}, 1'b1}
                     : pc + {{(PC_W-1){1'b0}}, 1'b1};

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state    <= st_idle;
            op_q     <= op_nop;
            idx_q    <= 5'h00;
            bit_q    <= 3'h0;
            off_q    <= 7'h00;
            taken_q  <= 1'b0;
            cycles_q <= 4'h0;
        end else begin
            unique case (state)
                st_idle: begin
                    if (launch) begin
                        op_q  <= bof_op_type'(wdata_q[`BOF_CMD_OP_LSB +: 5]);
                        idx_q <= wdata_q[`BOF_CMD_IDX_LSB +: 5];
                        bit_q <= wdata_q[`BOF_CMD_BIT_LSB +: 3];
                        off_q <= wdata_q[`BOF_CMD_OFF_LSB +: 7];
                        state <= st_exec;
                    end
                end
                st_exec: begin
                    taken_q  <= is_branch && long_op;
                    cycles_q <= long_op ? `BOF_CYC_LONG
                                        : `BOF_CYC_SHORT;
                    state    <= long_op ? st_wait : st_idle;
                end
                st_wait: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Status flags and program counter
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag <= `BOF_FLAG_RESET;
        end else if (state == st_exec) begin
            flag <= next_flag;
        end else if (fire && sel_flag && !busy && wstrb[0]) begin
            flag <= wdata_q[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc <= `BOF_PC_RESET;
        end else if (state == st_exec) begin
            pc <= next_pc;
        end else if (fire && sel_pc && !busy) begin
            pc <= wdata_q[PC_W-1:0];
        end
    end

    // Error bits hold until the next command write, which rewrites both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            illegal <= 1'b0;
            refused <= 1'b0;
        end else if (fire && sel_cmd) begin
            illegal <= !busy && !legal_op;
            refused <= busy;
        end
    end

    // ------------------------------------------------------------------------
    // I/O registers, one per entry
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < IO_N; gi++) begin : g_io
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    io_reg[gi] <= 8'h00;
                end else if (state == st_exec && io_we
                             && idx_q[2:0] == 3'(gi)) begin
                    io_reg[gi][bit_q] <= io_val;
                end else if (fire && sel_io && !busy && wstrb[0]
                             && waddr_q[4:2] == 3'(gi)) begin
                    io_reg[gi] <= wdata_q[7:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // General registers
    // ------------------------------------------------------------------------
    logic       rf_we;
    logic [4:0] rf_waddr;
    logic [7:0] rf_wdata;

    // Bus writes only land while idle, so they never meet a write-back
    assign rf_we    = (state == st_exec && gpr_we)
                   || (fire && sel_gpr && !busy && wstrb[0]);
    assign rf_waddr = (state == st_exec) ? idx_q : waddr_q[6:2];
    assign rf_wdata = (state == st_exec) ? res : wdata_q[7:0];

    bof_regfile #(
        .WIDTH (8),
        .DEPTH (GPR_N),
        .AW    (5)
    ) u_regfile (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (rf_we),
        .wr_addr (rf_waddr),
        .wr_data (rf_wdata),
        .a_addr  (wdata_q[`BOF_CMD_IDX_LSB +: 5]),
        .a_data  (opnd),
        .b_addr  (raddr_q[6:2]),
        .b_data  (gpr_rd)
    );

    // ------------------------------------------------------------------------
    // AXI4-Lite write side
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            awready <= 1'b0;
            waddr_q <= '0;
        end else if (awvalid && awready) begin
            aw_have <= 1'b1;
            awready <= 1'b0;
            waddr_q <= {awaddr[ADDR_W-1:2], 2'b00};
        end else if (bvalid && bready) begin
            aw_have <= 1'b0;
            awready <= 1'b1;
        end else if (!aw_have) begin
            awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have  <= 1'b0;
            wready  <= 1'b0;
            wdata_q <= 32'h0000_0000;
        end else if (wvalid && wready) begin
            w_have  <= 1'b1;
            wready  <= 1'b0;
            wdata_q <= wdata & {{8{wstrb[3]}}, {8{wstrb[2]}},
                                {8{wstrb[1]}}, {8{wstrb[0]}}};
        end else if (bvalid && bready) begin
            w_have <= 1'b0;
            wready <= 1'b1;
        end else if (!w_have) begin
            wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `BOF_RESP_OKAY;
        end else if (fire) begin
            bvalid <= 1'b1;
            bresp  <= (w_ok && !(sel_cmd && !legal_op)) ? `BOF_RESP_OKAY
                                                       : `BOF_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite read side; two cycles to let the register file answer
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready  <= 1'b0;
            raddr_q  <= '0;
            rd_stage <= 2'h0;
            rvalid   <= 1'b0;
            rdata    <= 32'h0000_0000;
            rresp    <= `BOF_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready  <= 1'b0;
            raddr_q  <= {araddr[ADDR_W-1:2], 2'b00};
            rd_stage <= 2'h1;
        end else if (rd_stage == 2'h1) begin
            rd_stage <= 2'h2;
        end else if (rd_stage == 2'h2) begin
            rd_stage <= 2'h0;
            rvalid   <= 1'b1;
            rresp    <= `BOF_RESP_OKAY;
            if (raddr_q == `BOF_ADDR_STATUS) begin
                rdata <= {20'h00000, cycles_q, 4'h0, refused, taken_q,
                          illegal, busy};
            end else if (raddr_q == `BOF_ADDR_FLAG) begin
                rdata <= {24'h000000, flag};
            end else if (raddr_q == `BOF_ADDR_PC) begin
                rdata <= {{(32-PC_W){1'b0}}, pc};
            end else if (raddr_q[7:5] == `BOF_IO_REGION) begin
                rdata <= {24'h000000, io_reg[raddr_q[4:2]]};
            end else if (raddr_q[7] == `BOF_GPR_REGION) begin
                rdata <= {24'h000000, gpr_rd};
            end else begin
                rdata <= 32'h0000_0000;
                rresp <= (raddr_q == `BOF_ADDR_CMD) ? `BOF_RESP_OKAY
                                                    : `BOF_RESP_SLVERR;
            end
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end else if (!rvalid && rd_stage == 2'h0) begin
            arready <= 1'b1;
        end
    end

endmodule : bof_datapath

// File: tb/bof_datapath_properties.sv
// Port timing assertions for the bit-op datapath
`timescale 1ns/1ps

module bof_datapath_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write channels
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    // Read channels
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_W_LAT: assert property (awvalid && awready && wvalid && wready
        |=> !bvalid ##1 bvalid) else $error("write answer late");
    AST_R_LAT: assert property (arvalid && arready
        |=> !rvalid [*2] ##1 rvalid) else $error("read answer late");
    AST_B_DONE: assert property (bvalid && bready
        |=> !bvalid && awready && wready) else $error("write not closed");
    AST_R_DONE: assert property (rvalid && rready
        |=> !rvalid && arready) else $error("read not closed");
    AST_AW_QUIET: assert property (awvalid && awready
        |=> !awready [*2]) else $error("awready back too soon");
    AST_AR_QUIET: assert property (arvalid && arready
        |=> !arready [*3]) else $error("arready back too soon");
    AST_B_BLOCK: assert property (bvalid |-> !awready && !wready)
        else $error("write taken during answer");
    // Reset is checked unmasked, so the default disable is overridden
    AST_RST: assert property (disable iff (1'b0) !aresetn
        |=> !bvalid && !rvalid && !awready && !arready)
        else $error("outputs not cleared by reset");
endmodule : bof_datapath_checker

bind bof_datapath bof_datapath_checker u_chk (.aclk, .aresetn, .awvalid,
    .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready,
    .rvalid, .rready);

// File: tb/test_bof_datapath.sv
// Self-checking bench for the bit-op datapath
`timescale 1ns/1ps
`include "bof_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module test_bof_datapath import bof_pkg::*; ;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    int errors, n_tests;

    // Answers are always accepted at once, so bready and rready never drop
    bof_datapath DUT (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid,
        .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready);

    // ------
    // Bus tasks
    // ------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        `CHK(bresp, `BOF_RESP_OKAY)
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        `CHK(d, e)
        `CHK(rresp, `BOF_RESP_OKAY)
    endtask : rchk

    // Polls status until idle and returns its cycle count field
    task automatic op(input bof_op_type c, input logic [4:0] i,
                      input logic [2:0] b, input logic [6:0] k,
                      output logic [3:0] cyc);
        logic [31:0] st;
        wr(`BOF_ADDR_CMD, {1'b0, k, 5'h0, b, 3'h0, i, 3'h0, c});
        do rd(`BOF_ADDR_STATUS, st);
        while (st[`BOF_ST_BUSY] !== 1'b0);
        cyc = st[11:8];
    endtask : op

    function automatic logic [8:0] shf(input bof_op_type o,
                                       input logic [7:0] v);
        case (o)
            op_logical_shift_left:         shf = {v, 1'b0};
            op_logical_shift_right:        shf = {v[0], 1'b0, v[7:1]};
            op_rotate_left_through_carry:  shf = {v, 1'b1};
            op_rotate_right_through_carry: shf = {v[0], 1'b1, v[7:1]};
            default:                       shf = {v[0], v[7], v[7:1]};
        endcase
    endfunction : shf

    // ------
    // Scenarios
    // ------
    task automatic t_branch();
        logic [3:0] c;
        wr(`BOF_ADDR_FLAG, 32'h80);
        wr(`BOF_ADDR_PC, 32'h10);
        op(op_branch_if_interrupts_on, 5'h0, 3'h0, 7'h05, c);
        `CHK(c, `BOF_CYC_LONG)
        rchk(`BOF_ADDR_PC, 32'h16);
        op(op_branch_if_interrupts_off, 5'h0, 3'h0, 7'h7d, c);
        `CHK(c, `BOF_CYC_SHORT)
        rchk(`BOF_ADDR_PC, 32'h17);
        wr(`BOF_ADDR_FLAG, 32'h7f);
        op(op_branch_if_interrupts_off, 5'h0, 3'h0, 7'h7d, c);
        rchk(`BOF_ADDR_PC, 32'h15);
        op(op_branch_if_interrupts_on, 5'h0, 3'h0, 7'h7d, c);
        rchk(`BOF_ADDR_PC, 32'h16);
        rchk(`BOF_ADDR_FLAG, 32'h7f);
        $display("branch test done");
    endtask : t_branch

    task automatic t_io();
        logic [3:0] c;
        wr(8'h4c, 32'h50);
        wr(`BOF_ADDR_FLAG, 32'h2b);
        op(op_set_io_bit, 5'h3, 3'h2, 7'h0, c);
        `CHK(c, `BOF_CYC_LONG)
        rchk(8'h4c, 32'h54);
        op(op_clear_io_bit, 5'h3, 3'h6, 7'h0, c);
        `CHK(c, `BOF_CYC_LONG)
        rchk(8'h4c, 32'h14);
        rchk(`BOF_ADDR_FLAG, 32'h2b);
        $display("io bit test done");
    endtask : t_io

    // Old carry is one, S and H set, to show what is kept
    task automatic t_shift();
        logic [3:0] c;
        logic [8:0] x;
        logic [7:0] v;
        for (int j = 5; j < 10; j++) begin
            for (int n = 0; n < 2; n++) begin
                v = n ? 8'h01 : 8'h80;
                x = shf(bof_op_type'(j), v);
                wr(8'h9c, {24'h0, v});
                wr(`BOF_ADDR_FLAG, 32'h31);
                op(bof_op_type'(j), 5'h7, 3'h0, 7'h0, c);
                `CHK(c, `BOF_CYC_SHORT)
                rchk(8'h9c, {24'h0, x[7:0]});
                rchk(`BOF_ADDR_FLAG, {28'h3, x[7] ^ x[8], x[7],
                    x[7:0] == 8'h0, x[8]});
            end
        end
        $display("shift test done");
    endtask : t_shift

    task automatic t_bits();
        logic [3:0] c;
        wr(8'h88, 32'h08);
        wr(`BOF_ADDR_FLAG, 32'h0);
        op(op_bit_store_to_transfer_flag, 5'h2, 3'h3, 7'h0, c);
        rchk(`BOF_ADDR_FLAG, 32'h40);
        op(op_bit_load_from_transfer_flag, 5'h2, 3'h5, 7'h0, c);
        `CHK(c, `BOF_CYC_SHORT)
        rchk(8'h88, 32'h28);
        rchk(`BOF_ADDR_FLAG, 32'h40);
        $display("bit move test done");
    endtask : t_bits

    task automatic t_flags();
        logic [3:0] c;
        logic [7:0] e;
        int p [6] = '{`BOF_FLAG_S, `BOF_FLAG_S, `BOF_FLAG_V, `BOF_FLAG_V,
                      `BOF_FLAG_H, `BOF_FLAG_H};
        e = 8'hc7;
        wr(`BOF_ADDR_FLAG, 32'hc7);
        for (int j = 0; j < 6; j++) begin
            op(bof_op_type'(j + 12), 5'h0, 3'h0, 7'h0, c);
            e[p[j]] = (j % 2 == 0);
            rchk(`BOF_ADDR_FLAG, {24'h0, e});
        end
        $display("flag test done");
    endtask : t_flags

    task automatic stop_test();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    initial begin
        {errors, n_tests} = '0;
        {aresetn, awvalid, wvalid, arvalid} = '0;
        {bready, rready} = 2'h3;
        {awaddr, araddr, wdata} = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_branch();
        t_io();
        t_shift();
        t_bits();
        t_flags();
        stop_test();
    end

    // About sixty times the expected run length
    initial begin
        #200000;
        errors++;
        stop_test();
    end
endmodule : test_bof_datapath
